// ### pkg/bcpu_pkg.sv
// Constants, carrier types and decode helpers for the byte cpu subset.
package bcpu_pkg;

  // Timing: clocks that make up one machine cycle.
  localparam int unsigned MC_CLKS = 6;
  localparam int unsigned STEP_W  = 4;

  // Reset values.
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [7:0]  SP_RESET  = 8'h07;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  PORT_RESET = 8'hff;

  // Direct address at which the output port latch sits.
  localparam logic [7:0]  PORT_ADDR = 8'h90;

  // Page addressing: low bits replaced by the page jump and call.
  localparam int unsigned PAGE_BITS = 11;

  // Instruction lengths.
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  // Page jump and call: low five opcode bits.
  localparam logic [4:0] PAGE_JMP_LO  = 5'h01;
  localparam logic [4:0] PAGE_CALL_LO = 5'h11;

  // Arithmetic and logic groups: high nibble selects the operation.
  localparam logic [3:0] OPH_ADD     = 4'h2;
  localparam logic [3:0] OPH_ADD_CIN = 4'h3;
  localparam logic [3:0] OPH_AND     = 4'h5;

  // Low nibble selects the operand form.
  localparam logic [3:0] OPL_DIR_A   = 4'h2;
  localparam logic [3:0] OPL_DIR_IMM = 4'h3;
  localparam logic [3:0] OPL_IMM     = 4'h4;
  localparam logic [3:0] OPL_DIR     = 4'h5;

  // Boolean and branch opcodes seen by the length decoder.
  localparam logic [7:0] OP_CLR_BIT   = 8'hc2;
  localparam logic [7:0] OP_SET_BIT      = 8'hd2;
  localparam logic [7:0] OP_INV_BIT      = 8'hb2;
  localparam logic [7:0] OP_AND_CBIT     = 8'h82;
  localparam logic [7:0] OP_AND_CNBIT    = 8'hb0;
  localparam logic [7:0] OP_OR_CBIT      = 8'h72;
  localparam logic [7:0] OP_OR_CNBIT     = 8'ha0;
  localparam logic [7:0] OP_MOV_CBIT     = 8'ha2;
  localparam logic [7:0] OP_MOV_BITC     = 8'h92;
  localparam logic [7:0] OP_JMP_CY       = 8'h40;
  localparam logic [7:0] OP_JMP_NCY      = 8'h50;
  localparam logic [7:0] OP_JMP_BIT      = 8'h20;
  localparam logic [7:0] OP_JMP_NBIT     = 8'h30;
  localparam logic [7:0] OP_JMP_BIT_CLR  = 8'h10;
  localparam logic [7:0] OP_JMP_SHORT    = 8'h80;
  localparam logic [7:0] OP_JMP_ZERO     = 8'h60;
  localparam logic [7:0] OP_JMP_NZERO    = 8'h70;
  localparam logic [7:0] OP_JMP_LONG     = 8'h02;
  localparam logic [7:0] OP_DEC_JMP_DIR  = 8'hd5;
  localparam logic [3:0] OPH_CMP_JMP     = 4'hb;
  localparam logic [4:0] OP5_DEC_JMP_REG = 5'h1b;

  // Request to internal data RAM.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } bcpu_ram_req_s;

  // Architectural state seen from outside.
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  acc;
    logic        cy;
    logic        ac;
    logic        ov;
  } bcpu_stat_s;

  // Sum and flags of the byte adder.
  typedef struct packed {
    logic [7:0] sum;
    logic       cy;
    logic       ac;
    logic       ov;
  } bcpu_add_s;

  // Byte add split at bits 3 and 6 so each carry out is visible.
  function automatic bcpu_add_s bcpu_add8(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] hi;
    bcpu_add_s  r;
    lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    mid   = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
    hi    = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
    r.sum = {hi[0], mid[2:0], lo[3:0]};
    r.cy  = hi[1];
    r.ac  = lo[4];
    r.ov  = hi[1] ^ mid[3];
    return r;
  endfunction

  // Byte count of an opcode; anything not listed is one byte long.
  function automatic logic [1:0] bcpu_op_len(input logic [7:0] op);
    logic [1:0] n;
    n = LEN1;
    if (op[4:0] == PAGE_JMP_LO || op[4:0] == PAGE_CALL_LO) begin
      n = LEN2;
    end else if (op[7:4] inside {OPH_ADD, OPH_ADD_CIN, OPH_AND} &&
                 op[3:0] inside {OPL_IMM, OPL_DIR}) begin
      n = LEN2;
    end else if (op[7:4] == OPH_AND && op[3:0] == OPL_DIR_A) begin
      n = LEN2;
    end else if (op[7:4] == OPH_AND && op[3:0] == OPL_DIR_IMM) begin
      n = LEN3;
    end else if (op inside {OP_CLR_BIT, OP_SET_BIT, OP_INV_BIT,
                            OP_AND_CBIT, OP_AND_CNBIT, OP_OR_CBIT,
                            OP_OR_CNBIT, OP_MOV_CBIT, OP_MOV_BITC,
                            OP_JMP_CY, OP_JMP_NCY, OP_JMP_SHORT,
                            OP_JMP_ZERO, OP_JMP_NZERO}) begin
      n = LEN2;
    end else if (op inside {OP_JMP_BIT, OP_JMP_NBIT, OP_JMP_BIT_CLR,
                            OP_JMP_LONG, OP_DEC_JMP_DIR} ||
                 (op[7:4] == OPH_CMP_JMP && op[3:2] != 2'h0) ||
                 op[7:3] == OP5_DEC_JMP_REG) begin
      n = LEN3;
    end
    return n;
  endfunction

endpackage

// ### logic/bcpu_core.sv
// Fetch, decode and execute for the add, call, page jump and byte and subset.
`timescale 1ns/10ps
`default_nettype none

module bcpu_core
  import bcpu_pkg::*;
(
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Program memory, read combinationally at prog_addr.
  output logic [15:0]        prog_addr,
  input  wire logic [7:0]    prog_data,
  // Internal data RAM, read combinationally at ram_req.addr.
  output bcpu_ram_req_s      ram_req,
  input  wire logic [7:0]    ram_rdata,
  // Output port.
  input  wire logic [7:0]    port_pins,
  output logic [7:0]         port_latch,
  // Status.
  output bcpu_stat_s         stat,
  output logic [1:0]         instr_len,
  output logic               retire
);

  typedef enum logic [3:0] {
    S_OP, S_B2, S_B3, S_DEC, S_PTR, S_SRC, S_EXEC, S_PUSH, S_HOLD
  } bcpu_state_e;

  typedef enum logic [1:0] {M_REG, M_IND, M_DIR, M_IMM} bcpu_mode_e;

  bcpu_state_e         state_r;
  logic [STEP_W-1:0]   step_r;
  logic [15:0]         pc_r;
  logic [15:0]         prog_addr_r;
  logic [7:0]          op_r;
  logic [7:0]          b2_r;
  logic [7:0]          b3_r;
  logic [7:0]          src_r;
  logic [7:0]          acc_r;
  logic [7:0]          sp_r;
  logic                cy_r;
  logic                ac_r;
  logic                ov_r;
  logic [7:0]          latch_r;
  bcpu_ram_req_s       ram_r;
  logic [1:0]          len_r;
  logic                retire_r;
  logic [7:0]          pin_s1_r;
  logic [7:0]          pin_s2_r;
  logic [7:0]          pin_s3_r;
  logic [7:0]          pin_val_r;

  // Decoded view of the held opcode.
  logic                is_add;
  logic                is_add_with_carry_in;
  logic                is_and_acc;
  logic                is_and_dir;
  logic                is_jmp;
  logic                is_call;
  bcpu_mode_e          mode;
  logic [STEP_W-1:0]   last_step;
  logic [15:0]         page_target;
  logic [7:0]          and_mask;
  bcpu_add_s           add_res;
  logic [1:0]          fetch_len;

  // Operation group and operand form come straight from the opcode nibbles; page jump and call come from the low five bits.
  assign is_add     = op_r[7:4] == OPH_ADD  && op_r[3:2] != 2'h0;
  assign is_add_with_carry_in    = op_r[7:4] == OPH_ADD_CIN && op_r[3:2] != 2'h0;
  assign is_and_acc = op_r[7:4] == OPH_AND  && op_r[3:2] != 2'h0;
  assign is_and_dir = op_r[7:4] == OPH_AND &&
                      op_r[3:0] inside {OPL_DIR_A, OPL_DIR_IMM};
  assign is_jmp     = op_r[4:0] == PAGE_JMP_LO;
  assign is_call    = op_r[4:0] == PAGE_CALL_LO;

  // Low nibble 4 is immediate, 5 direct, 6-7 indirect, 8-f register.
  always_comb begin
    if (op_r[3]) begin
      mode = M_REG;
    end else if (op_r[1]) begin
      mode = M_IND;
    end else if (op_r[0]) begin
      mode = M_DIR;
    end else begin
      mode = M_IMM;
    end
  end

  // Two-cycle forms get twice the clock budget; the rest get one cycle.
  assign last_step = (is_jmp || is_call || (is_and_dir &&
                      op_r[3:0] == OPL_DIR_IMM)) ?
                     STEP_W'(2 * MC_CLKS - 1) :
                     STEP_W'(MC_CLKS - 1);

  // The page address replaces only bits 10-0 of the advanced counter.
  assign page_target = {pc_r[15:PAGE_BITS], op_r[7:5], b2_r};

  // Direct-destination and masks with either the accumulator or the literal.
  assign and_mask  = (op_r[3:0] == OPL_DIR_A) ? acc_r : b3_r;
  assign add_res   = bcpu_add8(acc_r, src_r, is_add_with_carry_in & cy_r);
  assign fetch_len = bcpu_op_len(prog_data);

  // Port pins pass three flops; a value counts once the last two agree.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r  <= PORT_RESET;
      pin_s2_r  <= PORT_RESET;
      pin_s3_r  <= PORT_RESET;
      pin_val_r <= PORT_RESET;
    end else begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_val_r <= pin_s3_r;
      end
    end
  end

  // Sequencer: byte fetch, operand gathering, execute, then pad to budget.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_OP;
      step_r  <= '0;
    end else begin
      step_r <= step_r + STEP_W'(1);
      unique case (state_r)
        S_OP: begin
          state_r <= (fetch_len == LEN1) ? S_DEC : S_B2;
        end
        S_B2: begin
          state_r <= (len_r == LEN3) ? S_B3 : S_DEC;
        end
        S_B3: begin
          state_r <= S_DEC;
        end
        S_DEC: begin
          if (is_call) begin
            state_r <= S_PUSH;
          end else if (is_add || is_add_with_carry_in || is_and_acc) begin
            unique case (mode)
              M_REG:   state_r <= S_SRC;
              M_IND:   state_r <= S_PTR;
              M_DIR:   state_r <= (b2_r == PORT_ADDR) ? S_EXEC : S_SRC;
              M_IMM:   state_r <= S_EXEC;
            endcase
          end else if (is_and_dir) begin
            state_r <= (b2_r == PORT_ADDR) ? S_EXEC : S_SRC;
          end else begin
            state_r <= S_HOLD;
          end
        end
        S_PTR:  state_r <= S_SRC;
        S_SRC:  state_r <= S_EXEC;
        S_EXEC: state_r <= S_HOLD;
        S_PUSH: state_r <= S_HOLD;
        S_HOLD: begin
          if (step_r == last_step) begin
            state_r <= S_OP;
            step_r  <= '0;
          end
        end
        default: begin
          state_r <= S_HOLD;
        end
      endcase
    end
  end

  // Opcode and operand bytes; the counter advances once per byte fetched.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_r        <= PC_RESET;
      prog_addr_r <= PC_RESET;
      op_r        <= '0;
      b2_r        <= '0;
      b3_r        <= '0;
      len_r       <= LEN1;
    end else begin
      unique case (state_r)
        S_OP: begin
          op_r        <= prog_data;
          len_r       <= fetch_len;
          pc_r        <= pc_r + 16'h0001;
          prog_addr_r <= pc_r + 16'h0001;
        end
        S_B2: begin
          b2_r        <= prog_data;
          pc_r        <= pc_r + 16'h0001;
          prog_addr_r <= pc_r + 16'h0001;
        end
        S_B3: begin
          b3_r <= prog_data;
          pc_r <= pc_r + 16'h0001;
        end
        S_DEC: begin
          if (is_jmp) begin
            pc_r <= page_target;
          end
        end
        S_PUSH: begin
          pc_r <= page_target;
        end
        S_HOLD: begin
          prog_addr_r <= pc_r;
        end
        default: begin
        end
      endcase
    end
  end

  // Data RAM port: operand reads, and write-back of pushes and and results.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ram_r <= '0;
    end else begin
      ram_r.we <= 1'b0;
      unique case (state_r)
        S_DEC: begin
          if (is_call) begin
            ram_r.addr  <= sp_r + 8'h01;
            ram_r.wdata <= pc_r[7:0];
            ram_r.we    <= 1'b1;
          end else if (is_and_dir) begin
            ram_r.addr <= b2_r;
          end else if (mode == M_REG) begin
            ram_r.addr <= {5'h00, op_r[2:0]};
          end else if (mode == M_IND) begin
            ram_r.addr <= {7'h00, op_r[0]};
          end else begin
            ram_r.addr <= b2_r;
          end
        end
        S_PTR: begin
          ram_r.addr <= ram_rdata;
        end
        S_PUSH: begin
          ram_r.addr  <= sp_r + 8'h01;
          ram_r.wdata <= pc_r[15:8];
          ram_r.we    <= 1'b1;
        end
        S_EXEC: begin
          if (is_and_dir && b2_r != PORT_ADDR) begin
            ram_r.wdata <= src_r & and_mask;
            ram_r.we    <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Source operand: RAM, the pins, the port latch or the literal byte.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= '0;
    end else if (state_r == S_SRC) begin
      src_r <= ram_rdata;
    end else if (state_r == S_DEC) begin
      if (is_and_dir) begin
        src_r <= latch_r;
      end else if (mode == M_DIR) begin
        src_r <= pin_val_r;
      end else begin
        src_r <= b2_r;
      end
    end
  end

  // Stack pointer is raised before each of the two return-address writes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= SP_RESET;
    end else if ((state_r == S_DEC && is_call) || state_r == S_PUSH) begin
      sp_r <= sp_r + 8'h01;
    end
  end

  // Accumulator and flags; calls, jumps and ands leave the flags alone.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= ACC_RESET;
      cy_r  <= 1'b0;
      ac_r  <= 1'b0;
      ov_r  <= 1'b0;
    end else if (state_r == S_EXEC) begin
      if (is_add || is_add_with_carry_in) begin
        acc_r <= add_res.sum;
        cy_r  <= add_res.cy;
        ac_r  <= add_res.ac;
        ov_r  <= add_res.ov;
      end else if (is_and_acc) begin
        acc_r <= acc_r & src_r;
      end
    end
  end

  // Port latch: and on the port address writes here, never to the RAM.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= PORT_RESET;
    end else if (state_r == S_EXEC && is_and_dir && b2_r == PORT_ADDR) begin
      latch_r <= src_r & and_mask;
    end
  end

  // One pulse on the clock after the last step of every instruction.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retire_r <= 1'b0;
    end else begin
      retire_r <= state_r == S_HOLD && step_r == last_step;
    end
  end

  // Every output is a flop or a bundle of flops.
  assign prog_addr  = prog_addr_r;
  assign ram_req    = ram_r;
  assign port_latch = latch_r;
  assign instr_len  = len_r;
  assign retire     = retire_r;
  assign stat       = '{pc: pc_r, sp: sp_r, acc: acc_r,
                        cy: cy_r, ac: ac_r, ov: ov_r};

endmodule // bcpu_core

`default_nettype wire

// ### tb/bcpu_core_sva.sv
// Port-level assertions for the byte cpu core.
`timescale 1ns/10ps
`default_nettype none

module bcpu_core_sva
  import bcpu_pkg::*;
(
  // Clock and reset.
  input wire logic          clock,
  input wire logic          rst_n,
  // Memory side.
  input wire logic [15:0]   prog_addr,
  input wire logic [7:0]    prog_data,
  input wire bcpu_ram_req_s ram_req,
  input wire logic [7:0]    ram_rdata,
  // Port and status.
  input wire logic [7:0]    port_pins,
  input wire logic [7:0]    port_latch,
  input wire bcpu_stat_s    stat,
  input wire logic [1:0]    instr_len,
  input wire logic          retire
);
  logic [7:0] gap_r;

  // Clocks since the last retire; it saturates so a hang cannot wrap it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) gap_r <= 8'h00;
    else if (retire) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // The first instruction after reset counts one clock more.
  AST_RETIRE_GAP: assert property (retire |-> gap_r inside
    {[8'd5:8'd6], [8'd11:8'd12]}) else $error("retire spacing wrong");
  AST_RETIRE_PULSE: assert property (retire |=> !retire [*5])
    else $error("retire too soon");
  AST_GAP_BOUND: assert property (gap_r < 8'd13)
    else $error("no retire within two machine cycles");
  AST_PUSH_PAIR: assert property (ram_req.we && $past(ram_req.we) |->
    ram_req.addr == $past(ram_req.addr) + 8'h01 && stat.sp == ram_req.addr)
    else $error("push pair out of order");
  AST_SP_STEP: assert property (!$stable(stat.sp) |->
    stat.sp == $past(stat.sp) + 8'h01 && ram_req.we)
    else $error("stack pointer moved without a push");
  AST_CALL_FLAGS: assert property (ram_req.we && $past(ram_req.we) |->
    $stable({stat.acc, stat.cy, stat.ac, stat.ov}))
    else $error("call touched accumulator or flags");
  AST_LATCH_AND: assert property (!$stable(port_latch) |->
    (port_latch & ~$past(port_latch)) == 8'h00)
    else $error("port latch gained a bit");
  AST_ALU_AT_END: assert property (!$stable({stat.acc, stat.cy,
    stat.ac, stat.ov}) |-> ##[1:2] retire)
    else $error("accumulator changed away from instruction end");
  AST_PORT_NO_RAM: assert property (ram_req.we |->
    ram_req.addr != PORT_ADDR) else $error("port address written to RAM");
  AST_LEN_VALID: assert property (instr_len != 2'h0)
    else $error("zero instruction length");
endmodule // bcpu_core_sva

bind bcpu_core bcpu_core_sva chk (
  .clock(clock), .rst_n(rst_n), .prog_addr(prog_addr),
  .prog_data(prog_data), .ram_req(ram_req), .ram_rdata(ram_rdata),
  .port_pins(port_pins), .port_latch(port_latch), .stat(stat),
  .instr_len(instr_len), .retire(retire));

`default_nettype wire

// ### tb/bcpu_mem_model.sv
// Program memory and internal data RAM facing the byte cpu core.
`timescale 1ns/10ps
`default_nettype none

module bcpu_mem_model
  import bcpu_pkg::*;
(
  // Clock.
  input  wire logic          clock,
  // Program memory.
  input  wire logic [15:0]   prog_addr,
  output logic [7:0]         prog_data,
  // Data RAM.
  input  wire bcpu_ram_req_s ram_req,
  output logic [7:0]         ram_rdata
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:255];

  // Both memories answer in the same cycle, as the core expects.
  assign prog_data = rom[prog_addr];
  assign ram_rdata = ram[ram_req.addr];

  // A write lands on the edge where the core holds the strobe.
  always @(posedge clock) begin
    if (ram_req.we) ram[ram_req.addr] <= ram_req.wdata;
  end
endmodule // bcpu_mem_model

`default_nettype wire

// ### tb/byte_cpu_add_call_and_subset_tb.sv
// Self-checking bench for the byte cpu core and its memories.
`timescale 1ns/10ps
`default_nettype none

module byte_cpu_add_call_and_subset_tb import bcpu_pkg::*;;
  typedef struct packed {
    logic [7:0] a;
    logic       cin;
    logic [7:0] op, b2, b3, src;
    logic       mem;
    logic [7:0] ex;
    logic [2:0] fl;
  } bcpu_row_s;

`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); \
  end \
end

  logic          clock, rst_n, retire;
  logic [15:0]   prog_addr, exp_pc;
  logic [7:0]    prog_data, ram_rdata, port_pins, port_latch;
  bcpu_ram_req_s ram_req;
  bcpu_stat_s    stat;
  logic [1:0]    instr_len;
  int            error_cnt, comparisons, cyc, p;

  // Accumulator, carry in, opcode, bytes, source, then what should result.
  bcpu_row_s rows [14] = '{
    '{8'hc3, 1'b0, 8'h2d, 8'h00, 8'h00, 8'haa, 1'b0, 8'h6d, 3'b101},
    '{8'hc3, 1'b1, 8'h27, 8'h00, 8'h00, 8'haa, 1'b0, 8'h6d, 3'b101},
    '{8'hc3, 1'b0, 8'h25, 8'h40, 8'h00, 8'h0d, 1'b0, 8'hd0, 3'b010},
    '{8'h40, 1'b0, 8'h24, 8'h40, 8'h00, 8'h40, 1'b0, 8'h80, 3'b001},
    '{8'hc3, 1'b1, 8'h3d, 8'h00, 8'h00, 8'haa, 1'b0, 8'h6e, 3'b101},
    '{8'hc3, 1'b0, 8'h37, 8'h00, 8'h00, 8'h3c, 1'b0, 8'hff, 3'b000},
    '{8'hc3, 1'b1, 8'h35, 8'h40, 8'h00, 8'h3d, 1'b0, 8'h01, 3'b110},
    '{8'hc3, 1'b1, 8'h34, 8'h0d, 8'h00, 8'h0d, 1'b0, 8'hd1, 3'b010},
    '{8'hc3, 1'b1, 8'h5d, 8'h00, 8'h00, 8'haa, 1'b0, 8'h82, 3'b110},
    '{8'hc3, 1'b1, 8'h57, 8'h00, 8'h00, 8'h0f, 1'b0, 8'h03, 3'b110},
    '{8'hc3, 1'b1, 8'h55, 8'h40, 8'h00, 8'hf0, 1'b0, 8'hc0, 3'b110},
    '{8'hc3, 1'b1, 8'h54, 8'h3c, 8'h00, 8'h3c, 1'b0, 8'h00, 3'b110},
    '{8'hc3, 1'b1, 8'h52, 8'h40, 8'h00, 8'h5a, 1'b1, 8'h42, 3'b110},
    '{8'hc3, 1'b1, 8'h53, 8'h40, 8'h0f, 8'h3c, 1'b1, 8'h0c, 3'b110}};

  // Length in the top two bits, opcode below.
  logic [9:0] ltab [30] = '{10'h1c3, 10'h2c2, 10'h1d3, 10'h2d2, 10'h1b3,
    10'h2b2, 10'h282, 10'h2b0, 10'h272, 10'h2a0, 10'h2a2, 10'h292, 10'h240,
    10'h250, 10'h320, 10'h330, 10'h310, 10'h132, 10'h280, 10'h302, 10'h173,
    10'h260, 10'h270, 10'h3b5, 10'h3b4, 10'h3b8, 10'h3b6, 10'h3d8, 10'h3d5,
    10'h100};

  bcpu_core DUT (.clock(clock), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .port_pins(port_pins), .port_latch(port_latch), .stat(stat),
    .instr_len(instr_len), .retire(retire));
  bcpu_mem_model mem (.clock(clock), .prog_addr(prog_addr),
    .prog_data(prog_data), .ram_req(ram_req), .ram_rdata(ram_rdata));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut short well past the few hundred clocks the run needs.
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // Memories are loaded only while the core sits in reset.
  task automatic start();
    @(negedge clock);
    rst_n = 1'b0;
    for (int j = 0; j < 4096; j++) mem.rom[j] = 8'h00;
    for (int j = 0; j < 256; j++) mem.ram[j] = 8'h00;
  endtask

  task automatic go();
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
  endtask

  // Returns in the cycle where the n-th retire pulse is seen.
  task automatic run_n(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 2000) begin
      @(negedge clock);
      k++;
      if (retire === 1'b1) n--;
    end
    // A missing retire is a mismatch, not a silent pass.
    if (n > 0) error_cnt++;
  endtask

  initial begin
    rst_n = 1'b0;
    port_pins = 8'h0f;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    start();
    `CHK(stat, {PC_RESET, SP_RESET, ACC_RESET, 3'b000})
    `CHK(port_latch, PORT_RESET)
    `CHK({ram_req, retire, instr_len}, {17'h0, 1'b0, LEN1})
    $display("reset test done");
    // The first two adds set the accumulator and carry for each row.
    foreach (rows[i]) begin
      start();
      mem.ram[5] = rows[i].src;
      mem.ram[1] = 8'h40;
      mem.ram[8'h40] = rows[i].src;
      mem.rom[0] = 8'h24;
      mem.rom[1] = rows[i].cin ? 8'hff : 8'h00;
      mem.rom[2] = 8'h24;
      mem.rom[3] = rows[i].a + {7'h0, rows[i].cin};
      mem.rom[4] = rows[i].op;
      mem.rom[5] = rows[i].b2;
      mem.rom[6] = rows[i].b3;
      go();
      run_n(3);
      if (rows[i].mem) begin
        `CHK(mem.ram[8'h40], rows[i].ex)
        `CHK(stat.acc, rows[i].a)
      end else begin
        `CHK(stat.acc, rows[i].ex)
      end
      `CHK({stat.cy, stat.ac, stat.ov}, rows[i].fl)
      $display("row %0d done", i);
    end
    // Boolean and branch opcodes only step the counter by their length.
    start();
    p = 0;
    foreach (ltab[i]) begin
      mem.rom[p] = ltab[i][7:0];
      p += ltab[i][9:8];
    end
    go();
    exp_pc = 16'h0000;
    foreach (ltab[i]) begin
      run_n(1);
      exp_pc += {14'h0, ltab[i][9:8]};
      `CHK(stat.pc, exp_pc)
      `CHK(instr_len, ltab[i][9:8])
    end
    $display("length test done");
    // Page jump, call, page jump, then a call whose return lands on a block edge.
    start();
    {mem.rom[0], mem.rom[1]} = 16'h2123;
    {mem.rom[16'h123], mem.rom[16'h124]} = 16'h7145;
    {mem.rom[16'h345], mem.rom[16'h346]} = 16'he1fe;
    {mem.rom[16'h7fe], mem.rom[16'h7ff]} = 16'h1110;
    go();
    run_n(1);
    `CHK(stat.pc, 16'h0123)
    run_n(1);
    `CHK(stat.pc, 16'h0345)
    `CHK({stat.sp, mem.ram[8], mem.ram[9]}, 24'h092501)
    run_n(2);
    `CHK(stat.pc, 16'h0810)
    `CHK(prog_addr, 16'h0810)
    `CHK({stat.sp, mem.ram[10], mem.ram[11]}, 24'h0b0008)
    `CHK({stat.cy, stat.ac, stat.ov}, 3'b000)
    $display("call test done");
    // The port read for and-into-port must come from the latch.
    start();
    {mem.rom[0], mem.rom[1], mem.rom[2], mem.rom[3]} = 32'h24ff24c4;
    {mem.rom[4], mem.rom[5], mem.rom[6]} = 24'h529053;
    {mem.rom[7], mem.rom[8], mem.rom[9], mem.rom[10]} = 32'h90f05590;
    go();
    run_n(5);
    `CHK(port_latch, 8'hc0)
    `CHK(mem.ram[8'h90], 8'h00)
    `CHK(stat.acc, 8'h03)
    `CHK({stat.cy, stat.ac, stat.ov}, 3'b110)
    $display("port test done");
    summarize();
  end
endmodule // byte_cpu_add_call_and_subset_tb

`default_nettype wire
